// File: spmc_map.svh
// Register map, field positions, reset values and timing constants of the power mode controller.
// Function
// - Two-bit mode field selects four power modes.
// - Port control bit 3 or PHY request powers down port.
// - Reset leaves mode field at normal.
// - Normal mode keeps clocks, PHY, MAC, host on.
// - From normal, any mode code write moves there.
// - Sleep after no energy beyond go-sleep time.
// - Low power keeps only receive energy detect.
// - Energy in low power returns to normal state.
// - Energy detect mode sends 120ns pulse each second.
// - Bit 2 disables PLL in energy detect mode.
// - Soft power down stops clocks, PHY, MAC; keeps registers.
// - Writing normal code leaves soft power down.
// - Power saving needs code 11, autoneg, no cable.
// - Power saving only turns receiver block off.
// - Power saving restores PHY on cable activity.
// - Power-down pin low powers down whole chip.
`ifndef SPMC_MAP_SVH
`define SPMC_MAP_SVH
`define SPMC_ADDR_P1_CTRL 8'h1D
`define SPMC_ADDR_P2_CTRL 8'h2D
`define SPMC_ADDR_MODE 8'hC3
`define SPMC_ADDR_SLEEP 8'hC4
`define SPMC_BIT_PORT_PD 3
`define SPMC_BIT_PLL_OFF 2
`define SPMC_MODE_LSB 0
`define SPMC_MODE_MSB 1
`define SPMC_RST_BYTE 8'h00
`define SPMC_PULSE_NS 120
`define SPMC_PULSE_PERIOD_NS 1000000000
`define SPMC_CLK_NS 100
`define SPMC_SLEEP_UNIT_NS 1000000
`endif

// File: spmc_pkg.sv
// Types shared by the power mode controller.
`default_nettype none
package spmc_pkg;
    typedef enum logic [1:0] {
        SPMC_NORMAL,
        SPMC_ENERGY,
        SPMC_SOFT_PD,
        SPMC_SAVING
    } spmc_mode_e;
    typedef enum logic [1:0] {
        SPMC_EPS_AWAKE,
        SPMC_EPS_ASLEEP
    } spmc_eps_e;
endpackage
`default_nettype wire

// File: spmc_switch_power_mode_controller.sv
// Power mode sequencer with its register slave, go-sleep timer and link pulse generator.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "spmc_map.svh"
module spmc_switch_power_mode_controller #(
    parameter int unsigned SLEEP_UNIT_CYC = (`SPMC_SLEEP_UNIT_NS + `SPMC_CLK_NS - 1) / `SPMC_CLK_NS,
    parameter int unsigned PULSE_PERIOD_CYC = `SPMC_PULSE_PERIOD_NS / `SPMC_CLK_NS
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic chip_power_down_n_i,
    input wire logic [1:0] phy_mgmt_pd_i,
    input wire logic [1:0] cable_energy_i,
    input wire logic autoneg_en_i,
    output logic pll_clk_en_o,
    output logic mac_en_o,
    output logic host_if_en_o,
    output logic [1:0] phy_tx_en_o,
    output logic [1:0] phy_rx_en_o,
    output logic [1:0] energy_det_en_o,
    output logic link_pulse_o,
    output logic low_power_o
);
    // Pulse width rounds up so a pulse never runs shorter than required.
    localparam int unsigned PULSE_CYC = (`SPMC_PULSE_NS + `SPMC_CLK_NS - 1) / `SPMC_CLK_NS;
    localparam int unsigned PULSE_CYC_SAFE = (PULSE_CYC < 1) ? 1 : PULSE_CYC;

    // Energy pins are asynchronous, so three stages; a change counts when stages two and three agree.
    logic [1:0] en_s1_q, en_s2_q, en_s3_q, en_flt_q;
    logic pd_s1_q, pd_s2_q, pd_s3_q, pd_flt_q;
    logic [1:0] en_flt_d;
    logic pd_flt_d;
    always_comb begin
        en_flt_d = en_flt_q;
        for (int i = 0; i < 2; i++) begin
            if (en_s2_q[i] == en_s3_q[i]) begin
                en_flt_d[i] = en_s3_q[i];
            end
        end
        pd_flt_d = (pd_s2_q == pd_s3_q) ? pd_s3_q : pd_flt_q;
    end
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            en_s1_q <= 2'h0;
            en_s2_q <= 2'h0;
            en_s3_q <= 2'h0;
            en_flt_q <= 2'h0;
            pd_s1_q <= 1'h1;
            pd_s2_q <= 1'h1;
            pd_s3_q <= 1'h1;
            pd_flt_q <= 1'h1;
        end else begin
            en_s1_q <= cable_energy_i;
            en_s2_q <= en_s1_q;
            en_s3_q <= en_s2_q;
            en_flt_q <= en_flt_d;
            pd_s1_q <= chip_power_down_n_i;
            pd_s2_q <= pd_s1_q;
            pd_s3_q <= pd_s2_q;
            pd_flt_q <= pd_flt_d;
        end
    end
    wire logic any_energy = |en_flt_q;

    // Register file; values survive every power mode, only reset clears them.
    logic [7:0] p1_q, p2_q, mode_q, sleep_q, rdata_q;
    logic [7:0] p1_d, p2_d, mode_d, sleep_d, rdata_d;
    always_comb begin
        p1_d = p1_q;
        p2_d = p2_q;
        mode_d = mode_q;
        sleep_d = sleep_q;
        rdata_d = 8'h00;
        if (reg_wr_i) begin
            if (reg_addr_i == `SPMC_ADDR_P1_CTRL) begin
                p1_d = reg_wdata_i;
            end else if (reg_addr_i == `SPMC_ADDR_P2_CTRL) begin
                p2_d = reg_wdata_i;
            end else if (reg_addr_i == `SPMC_ADDR_MODE) begin
                mode_d = reg_wdata_i;
            end else if (reg_addr_i == `SPMC_ADDR_SLEEP) begin
                sleep_d = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == `SPMC_ADDR_P1_CTRL) begin
                rdata_d = p1_q;
            end else if (reg_addr_i == `SPMC_ADDR_P2_CTRL) begin
                rdata_d = p2_q;
            end else if (reg_addr_i == `SPMC_ADDR_MODE) begin
                rdata_d = {mode_q[7:3], mode_q[2:0]};
            end else if (reg_addr_i == `SPMC_ADDR_SLEEP) begin
                rdata_d = sleep_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            p1_q <= `SPMC_RST_BYTE;
            p2_q <= `SPMC_RST_BYTE;
            mode_q <= `SPMC_RST_BYTE;
            sleep_q <= `SPMC_RST_BYTE;
            rdata_q <= 8'h00;
        end else begin
            p1_q <= p1_d;
            p2_q <= p2_d;
            mode_q <= mode_d;
            sleep_q <= sleep_d;
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata_o = rdata_q;
    // Read data stand for one cycle after the strobe and are zero otherwise, so several slaves can be ORed.
    property p_rdata_idle;
        @(posedge sys_clk_i) disable iff (!resetn_i) !reg_rd_i |=> (reg_rdata_o == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");
    property p_rdata_mode;
        @(posedge sys_clk_i) disable iff (!resetn_i) (reg_rd_i && reg_addr_i == `SPMC_ADDR_MODE) |=>
            (reg_rdata_o == $past(mode_q));
    endproperty
    a_rdata_mode: assert property (p_rdata_mode) else $error("mode byte read back wrong");
    // Stored bytes change only on a write, whatever power mode is active.
    property p_regs_hold;
        @(posedge sys_clk_i) disable iff (!resetn_i) !reg_wr_i |=>
            ($stable(mode_q) && $stable(sleep_q) && $stable(p1_q) && $stable(p2_q));
    endproperty
    a_regs_hold: assert property (p_regs_hold) else $error("register changed without a write");

    // The mode is decoded from the stored field, so it acts only once the write has landed.
    spmc_pkg::spmc_mode_e mode;
    assign mode = spmc_pkg::spmc_mode_e'(mode_q[`SPMC_MODE_MSB:`SPMC_MODE_LSB]);

    // Go-sleep timer: a prescaler of one unit and a unit count.
    // The count has a spare top bit, so an all-ones go-sleep byte cannot wrap and keep the block awake.
    spmc_pkg::spmc_eps_e eps_q, eps_d;
    logic [31:0] pre_q, pre_d;
    logic [8:0] units_q, units_d;
    always_comb begin
        eps_d = eps_q;
        pre_d = pre_q;
        units_d = units_q;
        if (mode != spmc_pkg::SPMC_ENERGY || any_energy) begin
            pre_d = 32'h0;
            units_d = 9'h000;
            eps_d = spmc_pkg::SPMC_EPS_AWAKE;
        end else begin
            case (eps_q)
                spmc_pkg::SPMC_EPS_AWAKE: begin
                    if (units_q > {1'b0, sleep_q}) begin
                        eps_d = spmc_pkg::SPMC_EPS_ASLEEP;
                    end else if (pre_q == SLEEP_UNIT_CYC - 1) begin
                        pre_d = 32'h0;
                        units_d = units_q + 9'h001;
                    end else begin
                        pre_d = pre_q + 32'h1;
                    end
                end
                default: begin
                    eps_d = spmc_pkg::SPMC_EPS_ASLEEP;
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            eps_q <= spmc_pkg::SPMC_EPS_AWAKE;
            pre_q <= 32'h0;
            units_q <= 9'h000;
        end else begin
            eps_q <= eps_d;
            pre_q <= pre_d;
            units_q <= units_d;
        end
    end
    wire logic asleep = (eps_q == spmc_pkg::SPMC_EPS_ASLEEP);
    // Sleep may come only once the silence has outlasted the programmed go-sleep time.
    property p_sleep_early;
        @(posedge sys_clk_i) disable iff (!resetn_i) (!asleep && units_q <= {1'b0, sleep_q}) |=> !asleep;
    endproperty
    a_sleep_early: assert property (p_sleep_early) else $error("slept before the go-sleep time");
    property p_sleep_entry;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (mode == spmc_pkg::SPMC_ENERGY && !any_energy && !asleep && units_q > {1'b0, sleep_q}) |=> asleep;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep after the go-sleep time");

    // Link pulse generator for energy detect mode; period counter restarts on entry.
    logic [31:0] per_q, per_d;
    logic pulse_q, pulse_d;
    always_comb begin
        per_d = 32'h0;
        pulse_d = 1'b0;
        if (mode == spmc_pkg::SPMC_ENERGY && pd_flt_q) begin
            per_d = (per_q == PULSE_PERIOD_CYC - 1) ? 32'h0 : per_q + 32'h1;
            pulse_d = (per_q < PULSE_CYC_SAFE);
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            per_q <= 32'h0;
            pulse_q <= 1'b0;
        end else begin
            per_q <= per_d;
            pulse_q <= pulse_d;
        end
    end
    assign link_pulse_o = pulse_q;

    // Block enables per mode; the hardware pin overrides everything.
    logic pll_d, mac_d, host_d, lowp_d;
    logic [1:0] tx_d, rx_d, ed_d, port_pd;
    logic pll_q, mac_q, host_q, lowp_q;
    logic [1:0] tx_q, rx_q, ed_q;
    assign port_pd = {p2_q[`SPMC_BIT_PORT_PD], p1_q[`SPMC_BIT_PORT_PD]} | phy_mgmt_pd_i;
    always_comb begin
        pll_d = 1'b1;
        mac_d = 1'b1;
        host_d = 1'b1;
        tx_d = 2'h3;
        rx_d = 2'h3;
        ed_d = 2'h3;
        lowp_d = 1'b0;
        case (mode)
            spmc_pkg::SPMC_ENERGY: begin
                pll_d = ~mode_q[`SPMC_BIT_PLL_OFF] & ~asleep;
                if (asleep) begin
                    mac_d = 1'b0;
                    host_d = 1'b0;
                    tx_d = 2'h0;
                    rx_d = 2'h0;
                    lowp_d = 1'b1;
                end
            end
            spmc_pkg::SPMC_SOFT_PD: begin
                pll_d = 1'b0;
                mac_d = 1'b0;
                tx_d = 2'h0;
                rx_d = 2'h0;
                ed_d = 2'h0;
                lowp_d = 1'b1;
            end
            spmc_pkg::SPMC_SAVING: begin
                if (autoneg_en_i) begin
                    rx_d = en_flt_q;
                end
            end
            default: begin
                pll_d = 1'b1;
            end
        endcase
        tx_d = tx_d & ~port_pd;
        rx_d = rx_d & ~port_pd;
        ed_d = ed_d & ~port_pd;
        if (!pd_flt_q) begin
            pll_d = 1'b0;
            mac_d = 1'b0;
            host_d = 1'b0;
            tx_d = 2'h0;
            rx_d = 2'h0;
            ed_d = 2'h0;
            lowp_d = 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pll_q <= 1'b1;
            mac_q <= 1'b1;
            host_q <= 1'b1;
            tx_q <= 2'h3;
            rx_q <= 2'h3;
            ed_q <= 2'h3;
            lowp_q <= 1'b0;
        end else begin
            pll_q <= pll_d;
            mac_q <= mac_d;
            host_q <= host_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            ed_q <= ed_d;
            lowp_q <= lowp_d;
        end
    end
    assign pll_clk_en_o = pll_q;
    assign mac_en_o = mac_q;
    assign host_if_en_o = host_q;
    assign phy_tx_en_o = tx_q;
    assign phy_rx_en_o = rx_q;
    assign energy_det_en_o = ed_q;
    assign low_power_o = lowp_q;

    // Checks on the sequencing outputs.
    property p_reset_normal;
        @(posedge sys_clk_i) !resetn_i |=> (mode_q[1:0] == 2'h0);
    endproperty
    a_reset_normal: assert property (p_reset_normal) else $error("mode not normal after reset");
    property p_soft_pd;
        @(posedge sys_clk_i) disable iff (!resetn_i) (mode == spmc_pkg::SPMC_SOFT_PD) |=>
            (!pll_q && !mac_q && tx_q == 2'h0);
    endproperty
    a_soft_pd: assert property (p_soft_pd) else $error("soft power down left blocks on");
    property p_normal_on;
        @(posedge sys_clk_i) disable iff (!resetn_i) (mode == spmc_pkg::SPMC_NORMAL && pd_flt_q) |=>
            (pll_q && mac_q && host_q);
    endproperty
    a_normal_on: assert property (p_normal_on) else $error("normal mode block off");
    property p_pin_pd;
        @(posedge sys_clk_i) disable iff (!resetn_i) !pd_flt_q |=> (!pll_q && !host_q && ed_q == 2'h0);
    endproperty
    a_pin_pd: assert property (p_pin_pd) else $error("pin power down ignored");
    property p_wake;
        @(posedge sys_clk_i) disable iff (!resetn_i) (asleep && any_energy) |=> !asleep ##1
            (!lowp_q || $past(mode) == spmc_pkg::SPMC_SOFT_PD || !$past(pd_flt_q));
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on energy");
    property p_port_pd;
        @(posedge sys_clk_i) disable iff (!resetn_i) p1_q[`SPMC_BIT_PORT_PD] |=> !tx_q[0];
    endproperty
    a_port_pd: assert property (p_port_pd) else $error("port one not powered down");
    property p_saving_tx;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (mode == spmc_pkg::SPMC_SAVING && pd_flt_q && port_pd == 2'h0) |=> (tx_q == 2'h3 && mac_q);
    endproperty
    a_saving_tx: assert property (p_saving_tx) else $error("power saving stopped transmitter");
    // The 120 ns pulse takes two 100 ns cycles; a third high cycle in a row means a stretched pulse.
    property p_pulse_width;
        @(posedge sys_clk_i) disable iff (!resetn_i) (pulse_q && $past(pulse_q)) |-> !$past(pulse_q, 2);
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("link pulse too wide");
    property p_sleep_restart;
        @(posedge sys_clk_i) disable iff (!resetn_i) any_energy |=> (units_q == 9'h000 && !asleep);
    endproperty
    a_sleep_restart: assert property (p_sleep_restart) else $error("sleep timer not restarted");
    property p_pulse_min;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            ($rose(pulse_q) && mode == spmc_pkg::SPMC_ENERGY && pd_flt_q) |=> pulse_q;
    endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("link pulse too narrow");
    property p_pulse_mode;
        @(posedge sys_clk_i) disable iff (!resetn_i) (mode != spmc_pkg::SPMC_ENERGY) |=> !pulse_q;
    endproperty
    a_pulse_mode: assert property (p_pulse_mode) else $error("link pulse outside energy detect");
    // Energy detect mode: only the receive energy detectors survive the low power state.
    property p_asleep_off;
        @(posedge sys_clk_i) disable iff (!resetn_i) (asleep && mode == spmc_pkg::SPMC_ENERGY && pd_flt_q) |=>
            (!pll_q && !mac_q && !host_q && tx_q == 2'h0 && rx_q == 2'h0 && ed_q == ~$past(port_pd));
    endproperty
    a_asleep_off: assert property (p_asleep_off) else $error("low power state left blocks on");
    property p_awake_on;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (mode == spmc_pkg::SPMC_ENERGY && !asleep && pd_flt_q && port_pd == 2'h0) |=>
            (tx_q == 2'h3 && rx_q == 2'h3 && mac_q);
    endproperty
    a_awake_on: assert property (p_awake_on) else $error("normal power state blocks off");
    property p_pll_bit;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (mode == spmc_pkg::SPMC_ENERGY && mode_q[`SPMC_BIT_PLL_OFF]) |=> !pll_q;
    endproperty
    a_pll_bit: assert property (p_pll_bit) else $error("PLL kept on despite disable bit");
    // Power saving and normal modes: the receivers follow the line only where the rules allow it.
    property p_saving_rx;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (mode == spmc_pkg::SPMC_SAVING && pd_flt_q && autoneg_en_i && port_pd == 2'h0) |=>
            (rx_q == $past(en_flt_q));
    endproperty
    a_saving_rx: assert property (p_saving_rx) else $error("receiver does not follow line energy");
    property p_normal_ports;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (mode == spmc_pkg::SPMC_NORMAL && pd_flt_q && port_pd == 2'h0) |=>
            (tx_q == 2'h3 && rx_q == 2'h3 && ed_q == 2'h3);
    endproperty
    a_normal_ports: assert property (p_normal_ports) else $error("normal mode port block off");
    property p_mgmt_pd;
        @(posedge sys_clk_i) disable iff (!resetn_i) phy_mgmt_pd_i[1] |=> (!tx_q[1] && !rx_q[1]);
    endproperty
    a_mgmt_pd: assert property (p_mgmt_pd) else $error("port two not powered down");
endmodule // spmc_switch_power_mode_controller
`default_nettype wire

// File: spmc_switch_power_mode_controller_bench.sv
// Self-checking testbench for the switch power mode controller.
`timescale 1ns/10ps
`default_nettype none
`include "spmc_map.svh"
module spmc_switch_power_mode_controller_bench;
    logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, chip_power_down_n_i, autoneg_en_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, mon;
    logic [1:0] phy_mgmt_pd_i, cable_energy_i, phy_tx_en_o, phy_rx_en_o, energy_det_en_o;
    logic pll_clk_en_o, mac_en_o, host_if_en_o, link_pulse_o, low_power_o;
    int error_cnt, samples_checked, cyc_cnt, n;

    // Short go-sleep unit and pulse period keep the run brief; expectations use these values.
    spmc_switch_power_mode_controller #(.SLEEP_UNIT_CYC(4), .PULSE_PERIOD_CYC(50)) uut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .chip_power_down_n_i(chip_power_down_n_i), .phy_mgmt_pd_i(phy_mgmt_pd_i),
        .cable_energy_i(cable_energy_i), .autoneg_en_i(autoneg_en_i), .pll_clk_en_o(pll_clk_en_o),
        .mac_en_o(mac_en_o), .host_if_en_o(host_if_en_o), .phy_tx_en_o(phy_tx_en_o),
        .phy_rx_en_o(phy_rx_en_o), .energy_det_en_o(energy_det_en_o), .link_pulse_o(link_pulse_o),
        .low_power_o(low_power_o));

    // Bit 1 low power, 2 pulse, 3 PLL, 4 MAC, 5 host, 6 and 7 receivers; bit 0 is spare.
    assign mon = {phy_rx_en_o, host_if_en_o, mac_en_o, pll_clk_en_o, link_pulse_o, low_power_o, 1'b0};

    // Free-running 10 MHz clock.
    always #50 sys_clk_i = ~sys_clk_i;

    // A hang is cut short well beyond the few hundred cycles the sequence needs.
    always @(posedge sys_clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Per-port enables together with PLL and MAC enables.
    task automatic st(input logic [7:0] exp);
        chk({phy_tx_en_o, phy_rx_en_o, energy_det_en_o, pll_clk_en_o, mac_en_o}, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        chk(reg_rdata_o, exp);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask

    // Bounded wait for one monitored output; a zero bound checks at once.
    task automatic wait_bit(input int idx, input logic v, input int maxc);
        int i;
        i = 0;
        while (mon[idx] !== v && i < maxc) begin
            @(negedge sys_clk_i);
            i++;
        end
        chk({7'h00, mon[idx]}, {7'h00, v});
    endtask

    // Main sequence; every mode code is written at least once.
    initial begin
        sys_clk_i = 1'b0;
        resetn_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        chip_power_down_n_i = 1'b1;
        autoneg_en_i = 1'b1;
        phy_mgmt_pd_i = 2'b00;
        cable_energy_i = 2'b11;
        error_cnt = 0;
        samples_checked = 0;
        repeat (16) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(`SPMC_ADDR_P1_CTRL, 8'h00);
        rd(`SPMC_ADDR_P2_CTRL, 8'h00);
        rd(`SPMC_ADDR_MODE, 8'h00);
        rd(`SPMC_ADDR_SLEEP, 8'h00);
        rd(8'h55, 8'h00);
        chk(mon, 8'hF8);
        st(8'hFF);
        wr(`SPMC_ADDR_P1_CTRL, 8'h08);
        settle(2);
        chk({phy_tx_en_o, phy_rx_en_o, 4'h0}, 8'hA0);
        wr(`SPMC_ADDR_P1_CTRL, 8'h00);
        @(posedge sys_clk_i);
        phy_mgmt_pd_i <= 2'b10;
        settle(2);
        chk({phy_tx_en_o, phy_rx_en_o, 4'h0}, 8'h50);
        @(posedge sys_clk_i);
        phy_mgmt_pd_i <= 2'b00;
        // Soft power down must leave stored bytes untouched.
        wr(`SPMC_ADDR_SLEEP, 8'h02);
        wr(`SPMC_ADDR_MODE, 8'h02);
        settle(2);
        st(8'h00);
        wait_bit(1, 1'b1, 0);
        rd(`SPMC_ADDR_SLEEP, 8'h02);
        rd(`SPMC_ADDR_MODE, 8'h02);
        wr(`SPMC_ADDR_MODE, 8'h00);
        settle(2);
        chk(mon, 8'hF8);
        // Energy detect mode with the cable live: pulse width and spacing.
        wr(`SPMC_ADDR_MODE, 8'h01);
        wait_bit(2, 1'b1, 60);
        n = 0;
        while (link_pulse_o === 1'b1 && n < 10) begin
            n++;
            @(negedge sys_clk_i);
        end
        chk(n[7:0], 8'h02);
        n = 0;
        while (link_pulse_o !== 1'b1 && n < 100) begin
            n++;
            @(negedge sys_clk_i);
        end
        chk(n[7:0], 8'h30);
        chk({phy_tx_en_o, phy_rx_en_o, 4'h0}, 8'hF0);
        wr(`SPMC_ADDR_MODE, 8'h05);
        wait_bit(3, 1'b0, 3);
        // Silence must last beyond two go-sleep units before the block sleeps.
        @(posedge sys_clk_i);
        cable_energy_i <= 2'b00;
        settle(10);
        wait_bit(1, 1'b0, 0);
        wait_bit(1, 1'b1, 40);
        st(8'h0C);
        @(posedge sys_clk_i);
        cable_energy_i <= 2'b11;
        wait_bit(1, 1'b0, 8);
        // Short silent spells broken by energy never add up to a sleep.
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk_i);
            cable_energy_i <= 2'b00;
            repeat (6) @(posedge sys_clk_i);
            cable_energy_i <= 2'b11;
            repeat (2) @(posedge sys_clk_i);
        end
        settle(4);
        wait_bit(1, 1'b0, 0);
        wr(`SPMC_ADDR_MODE, 8'h00);
        // Power saving turns only the receivers off while the cable is quiet.
        @(posedge sys_clk_i);
        cable_energy_i <= 2'b00;
        wr(`SPMC_ADDR_MODE, 8'h03);
        wait_bit(6, 1'b0, 8);
        chk(mon, 8'h38);
        chk({phy_tx_en_o, 6'h00}, 8'hC0);
        @(posedge sys_clk_i);
        cable_energy_i <= 2'b11;
        wait_bit(6, 1'b1, 8);
        wait_bit(7, 1'b1, 8);
        @(posedge sys_clk_i);
        cable_energy_i <= 2'b00;
        autoneg_en_i <= 1'b0;
        settle(8);
        wait_bit(6, 1'b1, 0);
        wr(`SPMC_ADDR_MODE, 8'h00);
        // A reset in mid-run from soft power down must bring back normal mode and clear the bytes.
        wr(`SPMC_ADDR_MODE, 8'h02);
        wr(`SPMC_ADDR_SLEEP, 8'h07);
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(`SPMC_ADDR_MODE, 8'h00);
        rd(`SPMC_ADDR_SLEEP, 8'h00);
        chk(mon, 8'hF8);
        // Hardware power-down pin.
        @(posedge sys_clk_i);
        chip_power_down_n_i <= 1'b0;
        wait_bit(1, 1'b1, 8);
        wait_bit(3, 1'b0, 0);
        @(posedge sys_clk_i);
        chip_power_down_n_i <= 1'b1;
        wait_bit(1, 1'b0, 8);
        print_verdict();
    end
endmodule // spmc_switch_power_mode_controller_bench
`default_nettype wire
